/* hdl/cmx_pkg.sv */
// constants for the serial register bank of the clock buffer
package cmx_pkg;
    // ==========================================
    // register indices
    localparam logic [7:0] IDX_ENABLES  = 8'h02;
    localparam logic [7:0] IDX_SWING    = 8'h03;
    localparam logic [7:0] IDX_RSVD4    = 8'h04;
    localparam logic [7:0] IDX_IDENT    = 8'h05;
    localparam logic [7:0] IDX_PART     = 8'h06;
    localparam logic [7:0] IDX_READ_LEN = 8'h07;
    localparam logic [7:0] IDX_RSVD8    = 8'h08;
    // ==========================================
    // values after reset, and the bits per byte
    localparam logic [3:0] RST_ENABLES  = 4'hF;
    localparam logic [2:0] RST_SWING    = 3'h4;
    localparam logic [4:0] RST_READ_LEN = 5'h08;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // ==========================================
    // bus engine states and byte roles
    typedef enum logic [2:0] {CMX_IDLE, CMX_RX, CMX_ACK, CMX_TX, CMX_MACK} cmx_state_t;
    typedef enum logic [1:0] {CMX_K_ADDR, CMX_K_CMD, CMX_K_CNT, CMX_K_DATA} cmx_kind_t;
endpackage : cmx_pkg

/* hdl/cmx_smbus_regs.sv */
// serial management slave with the upper register bytes 2 to 8
`timescale 1ns/100ps
// Function
// - A cleared enable bit for outputs 8 to 11 holds that output low whatever the OE pin.
// - The 3-bit swing field in byte 3 selects the output amplitude code.
// - A 5-bit writable byte-count field in byte 7 sets the count a block read returns; the read runs until a host not-acknowledge.
// - The byte count resets to 8 so that a block read covers bytes 0 to 7.
// - Byte 5 holds read-only revision and maker codes and byte 6 a read-only part code.
// - A block read first returns the byte count, then register bytes from the index.
module cmx_smbus_regs
    import cmx_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR      = 7'h6C,
    parameter logic [3:0] REVISION_CODE = 4'h3,  // arbitrary value
    parameter logic [3:0] MAKER_CODE    = 4'h5,  // arbitrary value
    parameter logic [7:0] PART_CODE     = 8'h5A  // arbitrary value
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       hw_oe_n,
    output logic [3:0]      out_active,
    output logic [2:0]      swing_code
);
    // ==========================================
    // pin synchronisers
    logic       scl_s1, scl_s2, scl_q;
    logic       sda_s1, sda_s2, sda_q;
    logic       oe_s1, oe_s2;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_q  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_q  <= 1'b1;
            oe_s1  <= 1'b1;
            oe_s2  <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_q  <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_q  <= sda_s2;
            oe_s1  <= hw_oe_n;
            oe_s2  <= oe_s1;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_s2 & ~scl_q;
    assign scl_fall  = ~scl_s2 & scl_q;
    assign bus_start = scl_s2 & scl_q & sda_q & ~sda_s2;
    assign bus_stop  = scl_s2 & scl_q & ~sda_q & sda_s2;

    // ==========================================
    // register contents
    logic [3:0] enables;
    logic [2:0] swing;
    logic [4:0] read_len;

    // bytes 0 and 1 live elsewhere, so they read as zero here
    function automatic logic [7:0] read_byte(input logic [7:0] idx, input logic [3:0] en,
                                             input logic [2:0] sw, input logic [4:0] len);
        logic [7:0] val;
        val = 8'h00;
        if (idx == IDX_ENABLES) begin
            val = {4'h0, en};
        end else if (idx == IDX_SWING) begin
            val = {5'h00, sw};
        end else if (idx == IDX_IDENT) begin
            val = {REVISION_CODE, MAKER_CODE};
        end else if (idx == IDX_PART) begin
            val = PART_CODE;
        end else if (idx == IDX_READ_LEN) begin
            val = {3'h0, len};
        end
        return val;
    endfunction : read_byte

    // ==========================================
    // bus engine
    cmx_state_t state, next_state;
    cmx_kind_t  kind, next_kind;
    logic [7:0] shift, next_shift;
    logic [3:0] bitcnt, next_bitcnt;
    logic [7:0] index, next_index;
    logic [7:0] wcount, next_wcount;
    logic       reading, next_reading;
    logic       tx_first, next_tx_first;
    logic       next_sda_oe_n;
    logic [3:0] next_enables;
    logic [2:0] next_swing;
    logic [4:0] next_read_len;
    logic [3:0] next_out_active;
    logic       wr_fire;
    logic [7:0] load_byte;

    always_comb begin
        next_state    = state;
        next_kind     = kind;
        next_shift    = shift;
        next_bitcnt   = bitcnt;
        next_index    = index;
        next_wcount   = wcount;
        next_reading  = reading;
        next_tx_first = tx_first;
        next_sda_oe_n = sda_oe_n;
        next_enables  = enables;
        next_swing    = swing;
        next_read_len = read_len;
        wr_fire       = 1'b0;
        next_out_active = enables & {4{~oe_s2}};
        // count goes out before any register byte
        load_byte     = tx_first ? {3'h0, read_len} : read_byte(index, enables, swing, read_len);
        if (bus_stop) begin
            next_state    = CMX_IDLE;
            next_sda_oe_n = 1'b1;
        end else if (bus_start) begin
            next_state    = CMX_RX;
            next_kind     = CMX_K_ADDR;
            next_bitcnt   = 4'h0;
            next_reading  = 1'b0;
            next_sda_oe_n = 1'b1;
        end else begin
            case (state)
                CMX_RX: begin
                    if (scl_rise) begin
                        next_shift  = {shift[6:0], sda_s2};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
                        next_bitcnt   = 4'h0;
                        next_sda_oe_n = 1'b0;
                        next_state    = CMX_ACK;
                        case (kind)
                            CMX_K_ADDR: begin
                                if (shift[7:1] != DEV_ADDR) begin
                                    next_sda_oe_n = 1'b1;
                                    next_state    = CMX_IDLE;
                                end else if (shift[0]) begin
                                    next_reading  = 1'b1;
                                    next_tx_first = 1'b1;
                                end else begin
                                    next_kind = CMX_K_CMD;
                                end
                            end
                            CMX_K_CMD: begin
                                next_index = shift;
                                next_kind  = CMX_K_CNT;
                            end
                            CMX_K_CNT: begin
                                next_wcount = shift;
                                next_kind   = CMX_K_DATA;
                            end
                            default: begin
                                if (wcount != 8'h00) begin
                                    wr_fire     = 1'b1;
                                    next_wcount = wcount - 8'h01;
                                    next_index  = index + 8'h01;
                                    if (index == IDX_ENABLES) next_enables = shift[3:0];
                                    if (index == IDX_SWING) next_swing = shift[2:0];
                                    if (index == IDX_READ_LEN) next_read_len = shift[4:0];
                                end
                            end
                        endcase
                    end
                end
                CMX_ACK: begin
                    if (scl_fall) begin
                        if (reading) begin
                            next_shift    = load_byte;
                            next_sda_oe_n = load_byte[7];
                            next_bitcnt   = 4'h1;
                            next_tx_first = 1'b0;
                            if (!tx_first) next_index = index + 8'h01;
                            next_state    = CMX_TX;
                        end else begin
                            next_sda_oe_n = 1'b1;
                            next_state    = CMX_RX;
                        end
                    end
                end
                CMX_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == BITS_PER_BYTE) begin
                            next_sda_oe_n = 1'b1;
                            next_bitcnt   = 4'h0;
                            next_state    = CMX_MACK;
                        end else begin
                            next_sda_oe_n = shift[6];
                            next_shift    = {shift[6:0], 1'b0};
                            next_bitcnt   = bitcnt + 4'h1;
                        end
                    end
                end
                CMX_MACK: begin
                    // host not-acknowledge ends the read
                    if (scl_rise) next_state = sda_s2 ? CMX_IDLE : CMX_ACK;
                end
                default: begin
                    next_state = CMX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state      <= CMX_IDLE;
            kind       <= CMX_K_ADDR;
            shift      <= 8'h00;
            bitcnt     <= 4'h0;
            index      <= 8'h00;
            wcount     <= 8'h00;
            reading    <= 1'b0;
            tx_first   <= 1'b0;
            sda_oe_n   <= 1'b1;
            sda_out    <= 1'b0;
            enables    <= RST_ENABLES;
            swing      <= RST_SWING;
            read_len   <= RST_READ_LEN;
            out_active <= 4'h0;
            swing_code <= RST_SWING;
        end else begin
            state      <= next_state;
            kind       <= next_kind;
            shift      <= next_shift;
            bitcnt     <= next_bitcnt;
            index      <= next_index;
            wcount     <= next_wcount;
            reading    <= next_reading;
            tx_first   <= next_tx_first;
            sda_oe_n   <= next_sda_oe_n;
            sda_out    <= 1'b0;
            enables    <= next_enables;
            swing      <= next_swing;
            read_len   <= next_read_len;
            out_active <= next_out_active;
            swing_code <= swing;
        end
    end

    // ==========================================
    // checks
    logic never_written;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) never_written <= 1'b1;
        else if (wr_fire) never_written <= 1'b0;
    end

    logic tx_load;
    assign tx_load = (state == CMX_ACK) && scl_fall && reading && !bus_start && !bus_stop;

    chk_enable_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> ((out_active & ~$past(enables)) == 4'h0)) else $error("output on while disabled");
    chk_swing_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> (swing_code == $past(swing))) else $error("swing code not followed");
    chk_len_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_fire && index == IDX_READ_LEN) |=> (read_len == $past(shift[4:0])))
        else $error("byte count not written");
    chk_len_default: assert property (@(posedge clk_sys) disable iff (!rst_n)
        never_written |-> (read_len == RST_READ_LEN)) else $error("byte count not default");
    chk_part_ident: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (tx_load && !tx_first && index == IDX_PART) |=> (shift == PART_CODE))
        else $error("part code wrong");
    chk_count_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (tx_load && tx_first) |=> (shift == {3'h0, $past(read_len)}) && (state == CMX_TX))
        else $error("count not sent first");
    chk_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (tx_load && !tx_first && (index == IDX_RSVD4 || index == IDX_RSVD8)) |=> (shift == 8'h00))
        else $error("reserved byte not zero");
endmodule : cmx_smbus_regs

/* test/cmx_host_model.sv */
// serial management host model driving clock and data toward the register bank
`timescale 1ns/100ps
module cmx_host_model (
    input  wire logic clk_sys,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv_n
);
    initial begin
        scl       = 1'b1;
        sda_drv_n = 1'b1;
    end
    // ==========================================
    // bus phases of four or eight system clocks so sync latency is covered
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    // works as first or repeated start: data released before clock rises
    task automatic start();
        sda_drv_n = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(8);
        sda_drv_n = 1'b0;
        tick(8);
        scl = 1'b0;
        tick(4);
    endtask : start
    task automatic stop();
        sda_drv_n = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(8);
        sda_drv_n = 1'b1;
        tick(8);
    endtask : stop
    task automatic bit_io(input logic b, output logic r);
        sda_drv_n = b;
        tick(4);
        scl = 1'b1;
        tick(4);
        r = sda_line;
        tick(4);
        scl = 1'b0;
        tick(4);
    endtask : bit_io
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack);
    endtask : wr_byte
    task automatic rd_byte(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nak, r);
    endtask : rd_byte
endmodule : cmx_host_model

/* test/testbench.sv */
// register bank testbench: block writes and reads through the host model
`timescale 1ns/100ps
module testbench;
    import cmx_pkg::*;
    localparam logic [7:0] WR_ADDR = 8'hD8;
    logic       clk_sys, rst_n, hw_oe_n, scl, sda_drv_n, sda_out, sda_oe_n, ack;
    wire        sda_line;
    logic [3:0] out_active;
    logic [2:0] swing_code;
    logic [7:0] rbuf [10];
    logic [7:0] exp_rst [7] = '{8'h0F, 8'h04, 8'h00, 8'h35, 8'h5A, 8'h08, 8'h00};
    logic [2:0] codes [4] = '{3'h1, 3'h3, 3'h5, 3'h7};
    int         bad_count, n_checks;
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // pull-up on the data wire, either party may pull it low
    assign sda_line = sda_drv_n & (sda_oe_n | sda_out);
    cmx_smbus_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .hw_oe_n(hw_oe_n), .out_active(out_active),
        .swing_code(swing_code));
    cmx_host_model i_host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
        .sda_drv_n(sda_drv_n));
    // ==========================================
    // shared tasks
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr1(input logic [7:0] idx, input logic [7:0] d);
        i_host.start();
        i_host.wr_byte(WR_ADDR, ack);
        check("address ack", {7'h00, ack}, 8'h00); // address accepted
        i_host.wr_byte(idx, ack);
        i_host.wr_byte(8'h01, ack);
        i_host.wr_byte(d, ack);
        check("data ack", {7'h00, ack}, 8'h00); // data accepted
        i_host.stop();
    endtask : wr1
    task automatic rd(input logic [7:0] idx, input int n);
        i_host.start();
        i_host.wr_byte(WR_ADDR, ack);
        i_host.wr_byte(idx, ack);
        i_host.start();
        i_host.wr_byte(WR_ADDR | 8'h01, ack);
        i_host.rd_byte(1'b0, rbuf[0]);
        for (int i = 0; i < n; i++) i_host.rd_byte(i == n - 1, rbuf[i + 1]);
        i_host.stop();
    endtask : rd
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    // ==========================================
    // tests
    initial begin
        rst_n   = 1'b0;
        hw_oe_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys) rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        rd(8'h02, 7);
        check("count", rbuf[0], 8'h08); // reset count
        for (int i = 0; i < 7; i++) check("reset byte", rbuf[i + 1], exp_rst[i]);
        check("outputs", {4'h0, out_active}, 8'h0F); // enabled at reset
        check("swing", {5'h00, swing_code}, 8'h04); // reset code
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            wr1(8'h03, {5'h1F, codes[i]});
            rd(8'h03, 1);
            check("swing byte", rbuf[1], {5'h00, codes[i]}); // code readback
            check("swing pins", {5'h00, swing_code}, {5'h00, codes[i]}); // code output
        end
        $display("test amplitude done");
        // one byte past the block count must be acked and dropped
        i_host.start();
        i_host.wr_byte(WR_ADDR, ack);
        i_host.wr_byte(8'h02, ack);
        i_host.wr_byte(8'h01, ack);
        i_host.wr_byte(8'hF5, ack);
        i_host.wr_byte(8'h00, ack);
        check("extra ack", {7'h00, ack}, 8'h00); // byte past count acked
        i_host.stop();
        rd(8'h02, 2);
        check("enable byte", rbuf[1], 8'h05); // enable readback
        check("swing kept", rbuf[2], 8'h07); // byte past count ignored
        check("outputs on", {4'h0, out_active}, 8'h05); // cleared bits low
        hw_oe_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        check("outputs off", {4'h0, out_active}, 8'h00); // pin disables
        hw_oe_n = 1'b0;
        $display("test enables done");
        wr1(8'h05, 8'h00);
        wr1(8'h06, 8'h00);
        wr1(8'h07, 8'hE3);
        rd(8'h05, 4);
        check("new count", rbuf[0], 8'h03); // count first
        check("ident", rbuf[1], 8'h35); // read only
        check("part", rbuf[2], 8'h5A); // read only
        check("len byte", rbuf[3], 8'h03); // count field
        check("rsvd8", rbuf[4], 8'h00); // reserved zero
        i_host.start();
        i_host.wr_byte(8'hB0, ack);
        check("foreign ack", {7'h00, ack}, 8'h01); // other address ignored
        i_host.stop();
        @(negedge clk_sys) rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        rd(8'h07, 1);
        check("count again", rbuf[0], 8'h08); // count after second reset
        $display("test count and identity done");
        print_verdict();
    end
    initial begin
        repeat (90000) @(posedge clk_sys);
        bad_count++;
        print_verdict();
    end
endmodule : testbench
